// ### rtl/bxc_pkg.sv
// Package: constants and types for the transceiver and pin control registers
package bxc_pkg;

  // ==========================================================
  // Frame layout
  // ==========================================================
  localparam int unsigned FRAME_BITS = 16;       // Bits in one write frame
  localparam logic [4:0]  FRAME_CNT_FULL = 5'h10; // Bit count of a whole frame
  localparam logic [1:0]  OP_WRITE = 2'h1;       // Top two bits of a write frame

  // ==========================================================
  // Register addresses (5-bit field of the first byte)
  // ==========================================================
  localparam logic [4:0] ADDR_XCVR_CTRL = 5'h10; // bus_transceiver_control
  localparam logic [4:0] ADDR_PIN_CFG   = 5'h11; // general_pin_config

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] XCVR_CTRL_RST = 8'h80;  // Sleep with wake-up armed
  localparam logic [7:0] PIN_CFG_RST   = 8'h00;  // All pins off

  // ==========================================================
  // Transceiver control field positions
  // ==========================================================
  localparam int unsigned MODE_HI   = 7;         // Mode field top bit
  localparam int unsigned MODE_LO   = 6;         // Mode field low bit
  localparam int unsigned SLEW_HI   = 5;         // Slew field top bit
  localparam int unsigned SLEW_LO   = 4;         // Slew field low bit
  localparam int unsigned WAKE_SEL  = 3;         // Single or triple pulse
  localparam int unsigned FAIL_SEL  = 0;         // Early fault report

  // ==========================================================
  // Event counts
  // ==========================================================
  localparam logic [2:0] WAKE_PULSES_MULTI  = 3'h3; // Pulses for wake-up
  localparam logic [2:0] WAKE_PULSES_SINGLE = 3'h1; // Short wake-up
  localparam logic [2:0] FAIL_ID_PULSES     = 3'h5; // Pulses to identify fault

  // ==========================================================
  // Types
  // ==========================================================
  // Transceiver modes
  typedef enum logic [1:0] {
    XM_SLEEP   = 2'h0,
    XM_LISTEN  = 2'h1,
    XM_SLEEP_W = 2'h2,
    XM_ACTIVE  = 2'h3
  } bxc_xmode_t;

  // Driver edge speed as driven out
  typedef enum logic [1:0] {
    SL_FAST   = 2'h0,
    SL_MEDIUM = 2'h1,
    SL_SLOW   = 2'h2
  } bxc_slew_t;

  // Received frame
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] addr;
    logic       par;
    logic [7:0] data;
  } bxc_frame_t;

  // Per-pin drive controls
  typedef struct packed {
    logic [3:0] hs_en;
    logic [3:0] ls_en;
    logic [3:0] wake_en;
  } bxc_pins_t;

  // Frame receiver states, Gray coded along the path
  typedef enum logic [1:0] {
    FS_IDLE  = 2'b00,
    FS_SHIFT = 2'b01,
    FS_END   = 2'b11
  } bxc_fstate_t;

endpackage

// ### rtl/bxc_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module bxc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic        INIT  = 1'b0
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ==========================================================
  // Stages
  // ==========================================================
  logic [WIDTH-1:0] st1; // Metastable catch, read only by st2
  logic [WIDTH-1:0] st2; // Second stage
  logic [WIDTH-1:0] st3; // Third stage

  // Shift chain
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st1 <= {WIDTH{INIT}};
      st2 <= {WIDTH{INIT}};
      st3 <= {WIDTH{INIT}};
    end else if (ce_i) begin
      st1 <= async_i;
      st2 <= st1;
      st3 <= st2;
    end
  end

  // Accept a bit only when the two later stages agree
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_acc
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          sync_o[i] <= INIT;
        end else if (ce_i && (st2[i] == st3[i])) begin
          sync_o[i] <= st3[i];
        end
      end
    end
  endgenerate

endmodule

// ### rtl/bxc_ctrl.sv
// Transceiver and general pin control registers written over the serial port
`timescale 1ns/100ps

// Notes on behaviour
// RULE1: Address 10000 or 10001, second byte is data
// RULE2: Mode 00: sleep, bus wake-up ignored
// RULE3: Mode 01: receiver on, driver off
// RULE4: Mode 10: sleep, wake-up reported per device mode
// RULE5: Mode 11: transmit and receive enabled
// RULE6: Slew 00/11 fast, 01 medium, 10 slow
// RULE7: Bit 3: three pulses or one pulse
// RULE8: Bit 0 clear: report after five pulses
// RULE9: Bit 0 set: report on detection
// RULE10: First normal entry forces mode 10
// RULE11: Two bits per pin, pin 3 highest
// RULE12: Pin 3: off, wake, high side
// RULE13: Pin 2: off, wake, high side
// RULE14: Pin 1: off, wake, low, high side
// RULE15: Pin 0: off, wake, low, high side
// RULE16: Fault interrupt needs enable bit set
// RULE17: Update only after complete 16-bit frame
module bxc_ctrl
  import bxc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  // Serial port pins
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  // Bus side pins
  input  wire logic       transmit_data_input_i,
  input  wire logic       bus_dominant_i,
  // Device state from on-chip logic
  input  wire logic       normal_mode_i,
  input  wire logic       low_power_i,
  input  wire logic       fail_detect_i,
  input  wire logic       fail_int_en_i,
  // Register contents
  output logic [7:0]      xcvr_ctrl_o,
  output logic [7:0]      pin_cfg_o,
  // Transceiver controls
  output logic            xcvr_rx_en_o,
  output logic            xcvr_tx_en_o,
  output logic            xcvr_sleep_o,
  output bxc_slew_t       xcvr_slew_o,
  // Events
  output logic            wake_o,
  output logic            int_o,
  // Pin controls
  output bxc_pins_t       pins_o
);

  // ==========================================================
  // Functions
  // ==========================================================
  // Decode one pin field; low side exists only on pins 0 and 1
  function automatic logic [2:0] pin_dec(input logic [1:0] f,
                                         input logic       has_ls);
    logic [2:0] r; // {hs, ls, wake}
    r = 3'h0;
    case (f)
      2'h1:    r = 3'h1;
      2'h2:    r = has_ls ? 3'h2 : 3'h4;
      2'h3:    r = 3'h4;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // Decode the slew field
  function automatic bxc_slew_t slew_dec(input logic [1:0] f);
    bxc_slew_t s;
    s = SL_FAST;
    case (f)
      2'h1:    s = SL_MEDIUM;
      2'h2:    s = SL_SLOW;
      default: s = SL_FAST;
    endcase
    return s;
  endfunction

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [4:0] pins_s;   // Synchronised pin levels
  logic       sclk_s;   // Serial clock
  logic       cs_n_s;   // Chip select, active low
  logic       mosi_s;   // Serial data in
  logic       txd_s;    // Transmit data input, low is dominant
  logic       dom_s;    // Bus dominant indication

  bxc_sync #(
    .WIDTH (5),
    .INIT  (1'b1)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .async_i   ({spi_sclk_i, spi_cs_n_i, spi_mosi_i,
                 transmit_data_input_i, ~bus_dominant_i}),
    .sync_o    (pins_s)
  );

  assign sclk_s = pins_s[4];
  assign cs_n_s = pins_s[3];
  assign mosi_s = pins_s[2];
  assign txd_s  = pins_s[1];
  assign dom_s  = ~pins_s[0];

  // ==========================================================
  // Edge detection
  // ==========================================================
  logic sclk_d;  // Last serial clock
  logic cs_n_d;  // Last chip select
  logic txd_d;   // Last transmit data
  logic dom_d;   // Last bus dominant
  logic norm_d;  // Last normal mode level

  // Delayed copies for edge finding
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_d <= 1'b1;
      cs_n_d <= 1'b1;
      txd_d  <= 1'b1;
      dom_d  <= 1'b0;
      norm_d <= 1'b0;
    end else if (ce_i) begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
      txd_d  <= txd_s;
      dom_d  <= dom_s;
      norm_d <= normal_mode_i;
    end
  end

  logic sclk_rise;  // Sample point of serial data
  logic cs_fall;    // Frame start
  logic cs_rise;    // Frame end
  logic txd_pulse;  // Start of a dominant pulse on transmit data
  logic dom_pulse;  // Start of a dominant pulse on the bus
  logic norm_rise;  // Entry into normal mode

  assign sclk_rise = sclk_s & ~sclk_d;
  assign cs_fall   = ~cs_n_s & cs_n_d;
  assign cs_rise   = cs_n_s & ~cs_n_d;
  assign txd_pulse = ~txd_s & txd_d;
  assign dom_pulse = dom_s & ~dom_d;
  assign norm_rise = normal_mode_i & ~norm_d;

  // ==========================================================
  // Frame receiver
  // ==========================================================
  bxc_fstate_t fstate;     // Receiver state
  logic [15:0] shreg;      // Shifted frame bits, first bit ends on top
  logic [4:0]  bit_cnt;    // Bits taken in this frame
  bxc_frame_t  frame;      // Frame view of the shifter
  logic        frame_ok;   // Whole frame with write code

  assign frame = bxc_frame_t'(shreg);
  assign frame_ok = (bit_cnt == FRAME_CNT_FULL) && (frame.op == OP_WRITE);

  // State sequence of one frame
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fstate <= FS_IDLE;
    end else if (ce_i) begin
      case (fstate)
        FS_IDLE:  fstate <= cs_fall ? FS_SHIFT : FS_IDLE; // Start on select going low
        FS_SHIFT: fstate <= cs_rise ? FS_END : FS_SHIFT;  // Select released ends the frame
        FS_END:   fstate <= FS_IDLE;                      // One cycle to commit
        default:  fstate <= FS_IDLE;                      // Unused code recovers
      endcase
    end
  end

  // Shift data on serial clock rising edges
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shreg   <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (ce_i) begin
      if (cs_fall) begin
        bit_cnt <= 5'h00;
      end else if (fstate == FS_SHIFT && sclk_rise && !cs_n_s) begin
        shreg <= {shreg[14:0], mosi_s};
        // Saturate one past a whole frame so long frames fail
        if (bit_cnt <= FRAME_CNT_FULL) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  logic wr_xcvr; // Commit to transceiver control
  logic wr_pin;  // Commit to pin control

  // Commit only at frame end with exactly sixteen bits [RULE17]
  assign wr_xcvr = (fstate == FS_END) && frame_ok
                   && (frame.addr == ADDR_XCVR_CTRL); // [RULE1]
  assign wr_pin  = (fstate == FS_END) && frame_ok
                   && (frame.addr == ADDR_PIN_CFG);   // [RULE1]

  // ==========================================================
  // Registers
  // ==========================================================
  logic first_norm_done; // Normal mode entered at least once

  // Transceiver control, data from second byte
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xcvr_ctrl_o <= XCVR_CTRL_RST;
    end else if (ce_i) begin
      if (norm_rise && !first_norm_done) begin
        // Force sleep with wake-up on first normal entry [RULE10]
        xcvr_ctrl_o[MODE_HI:MODE_LO] <= XM_SLEEP_W;
      end else if (wr_xcvr) begin
        xcvr_ctrl_o <= frame.data; // [RULE1] [RULE17]
      end
    end
  end

  // Remember the first normal entry
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      first_norm_done <= 1'b0;
    end else if (ce_i && norm_rise) begin
      first_norm_done <= 1'b1; // [RULE10]
    end
  end

  // Pin configuration
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_cfg_o <= PIN_CFG_RST;
    end else if (ce_i && wr_pin) begin
      pin_cfg_o <= frame.data; // [RULE1] [RULE17]
    end
  end

  // ==========================================================
  // Transceiver state
  // ==========================================================
  bxc_xmode_t xmode; // Current mode field
  assign xmode = bxc_xmode_t'(xcvr_ctrl_o[MODE_HI:MODE_LO]);

  // Receiver, driver and sleep controls from the mode
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {xcvr_rx_en_o, xcvr_tx_en_o, xcvr_sleep_o} <= 3'h1;
      xcvr_slew_o  <= SL_FAST;
    end else if (ce_i) begin
      // {receive, transmit, sleep} per mode
      case (xmode)
        XM_LISTEN: {xcvr_rx_en_o, xcvr_tx_en_o, xcvr_sleep_o} <= 3'h4; // Listen only [RULE3]
        XM_ACTIVE: {xcvr_rx_en_o, xcvr_tx_en_o, xcvr_sleep_o} <= 3'h6; // Full operation [RULE5]
        default:   {xcvr_rx_en_o, xcvr_tx_en_o, xcvr_sleep_o} <= 3'h1; // Both sleep codes [RULE2] [RULE4]
      endcase
      xcvr_slew_o <= slew_dec(xcvr_ctrl_o[SLEW_HI:SLEW_LO]); // [RULE6]
    end
  end

  // ==========================================================
  // Bus wake-up
  // ==========================================================
  logic [2:0] wake_cnt;  // Dominant pulses seen while armed
  logic [2:0] wake_need; // Pulses that make a wake-up
  logic       wake_hit;  // Wake-up recognised this cycle

  assign wake_need = xcvr_ctrl_o[WAKE_SEL] ? WAKE_PULSES_SINGLE
                                           : WAKE_PULSES_MULTI; // [RULE7]
  assign wake_hit  = (xmode == XM_SLEEP_W) && dom_pulse
                     && (wake_cnt + 3'h1 >= wake_need);

  // Count pulses only when armed; mode 00 never counts [RULE2] [RULE4]
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_cnt <= 3'h0;
    end else if (ce_i) begin
      if (xmode != XM_SLEEP_W || wake_hit) begin
        wake_cnt <= 3'h0;
      end else if (dom_pulse) begin
        wake_cnt <= wake_cnt + 3'h1; // [RULE7]
      end
    end
  end

  // Wake-up to device in low power, one-cycle pulse [RULE4]
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_o <= 1'b0;
    end else if (ce_i) begin
      wake_o <= wake_hit && low_power_i;
    end
  end

  // ==========================================================
  // Bus failure reporting
  // ==========================================================
  logic [2:0] fail_cnt;  // Dominant transmit pulses during a failure
  logic       fail_seen; // Failure already reported
  logic       fail_rep;  // Report this cycle

  // Early report on detection, else after identification
  always_comb begin
    fail_rep = 1'b0;
    if (fail_detect_i && !fail_seen) begin
      if (xcvr_ctrl_o[FAIL_SEL]) begin
        fail_rep = 1'b1; // [RULE9]
      end else if (txd_pulse && (fail_cnt + 3'h1 >= FAIL_ID_PULSES)) begin
        fail_rep = 1'b1; // [RULE8]
      end
    end
  end

  // Track identification pulses; clear once the failure goes away
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fail_cnt  <= 3'h0;
      fail_seen <= 1'b0;
    end else if (ce_i) begin
      if (!fail_detect_i) begin
        fail_cnt  <= 3'h0;
        fail_seen <= 1'b0;
      end else begin
        if (fail_rep) begin
          fail_seen <= 1'b1;
        end
        if (txd_pulse && fail_cnt < FAIL_ID_PULSES) begin
          fail_cnt <= fail_cnt + 3'h1; // [RULE8]
        end
      end
    end
  end

  // Interrupt pulse: wake-up in normal mode, or enabled bus failure
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_o <= 1'b0;
    end else if (ce_i) begin
      int_o <= (wake_hit && normal_mode_i && !low_power_i) // [RULE4]
               || (fail_rep && fail_int_en_i);             // [RULE16]
    end
  end

  // ==========================================================
  // General pins
  // ==========================================================
  generate
    for (genvar p = 0; p < 4; p++) begin : g_pin
      logic [2:0] dec; // {hs, ls, wake} of this pin
      // Pins 0 and 1 have a low side, 2 and 3 only high [RULE12] [RULE13] [RULE14] [RULE15]
      assign dec = pin_dec(pin_cfg_o[2*p+1 -: 2], (p < 2) ? 1'b1 : 1'b0); // [RULE11]

      // Registered pin controls
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          {pins_o.hs_en[p], pins_o.ls_en[p], pins_o.wake_en[p]} <= 3'h0;
        end else if (ce_i) begin
          {pins_o.hs_en[p], pins_o.ls_en[p], pins_o.wake_en[p]} <= dec;
        end
      end
    end
  endgenerate

endmodule

// ### verification/bxc_ctrl_checker.sv
// Checker: port properties of the control register block
`timescale 1ns/100ps
module bxc_ctrl_checker
  import bxc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       spi_cs_n_i,
  input wire logic       normal_mode_i,
  input wire logic       low_power_i,
  input wire logic       fail_int_en_i,
  input wire logic [7:0] xcvr_ctrl_o,
  input wire logic [7:0] pin_cfg_o,
  input wire logic       xcvr_rx_en_o,
  input wire logic       xcvr_tx_en_o,
  input wire logic       xcvr_sleep_o,
  input wire bxc_slew_t  xcvr_slew_o,
  input wire logic       wake_o,
  input wire logic       int_o,
  input wire bxc_pins_t  pins_o
);
  // ==========================================================
  // Helpers
  // ==========================================================
  // Expected drive controls for a pin configuration byte
  function automatic bxc_pins_t pins_of(input logic [7:0] v);
    bxc_pins_t r;
    for (int p = 0; p < 4; p++) begin
      r.wake_en[p] = (v[2*p +: 2] == 2'h1);
      r.ls_en[p]   = (p < 2) && (v[2*p +: 2] == 2'h2);
      r.hs_en[p]   = (v[2*p +: 2] == 2'h3) || ((p > 1) && (v[2*p +: 2] == 2'h2));
    end
    return r;
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================
  // Properties
  // ==========================================================
  property p_mode_decode;
    ##1 (xcvr_rx_en_o == $past(xcvr_ctrl_o[6])) && (xcvr_tx_en_o == ($past(xcvr_ctrl_o[7:6]) == 2'h3))
      && (xcvr_sleep_o == !$past(xcvr_ctrl_o[6]));
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode controls disagree with field");
  property p_slew_decode;
    ##1 xcvr_slew_o == (($past(xcvr_ctrl_o[5:4]) == 2'h1) ? SL_MEDIUM :
                        ($past(xcvr_ctrl_o[5:4]) == 2'h2) ? SL_SLOW : SL_FAST);
  endproperty
  a_slew_decode: assert property (p_slew_decode) else $error("slew output disagrees with field");
  property p_pins_decode;
    ##1 pins_o == pins_of($past(pin_cfg_o));
  endproperty
  a_pins_decode: assert property (p_pins_decode) else $error("pin controls disagree with field");
  property p_wake_src;
    wake_o |-> $past(low_power_i) && ($past(xcvr_ctrl_o[7:6]) == 2'h2);
  endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake pulse without armed sleep");
  property p_int_src;
    int_o |-> $past(fail_int_en_i) || ($past(normal_mode_i) && ($past(xcvr_ctrl_o[7:6]) == 2'h2));
  endproperty
  a_int_src: assert property (p_int_src) else $error("interrupt pulse without a cause");
  property p_pulse_short;
    (wake_o || int_o) |=> !wake_o && !int_o;
  endproperty
  a_pulse_short: assert property (p_pulse_short) else $error("event output held too long");
  property p_pin_frame;
    $changed(pin_cfg_o) |-> $past(spi_cs_n_i, 2) && $past(spi_cs_n_i, 4);
  endproperty
  a_pin_frame: assert property (p_pin_frame) else $error("pin register moved inside a frame");
  property p_ctrl_frame;
    $changed(xcvr_ctrl_o) |-> ($past(spi_cs_n_i, 2) && $past(spi_cs_n_i, 4))
      || ($past(normal_mode_i) && (xcvr_ctrl_o[7:6] == 2'h2));
  endproperty
  a_ctrl_frame: assert property (p_ctrl_frame) else $error("control register moved without cause");
endmodule

bind bxc_ctrl bxc_ctrl_checker bxc_ctrl_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_cs_n_i(spi_cs_n_i),
  .normal_mode_i(normal_mode_i), .low_power_i(low_power_i), .fail_int_en_i(fail_int_en_i),
  .xcvr_ctrl_o(xcvr_ctrl_o), .pin_cfg_o(pin_cfg_o), .xcvr_rx_en_o(xcvr_rx_en_o), .xcvr_tx_en_o(xcvr_tx_en_o),
  .xcvr_sleep_o(xcvr_sleep_o), .xcvr_slew_o(xcvr_slew_o), .wake_o(wake_o), .int_o(int_o), .pins_o(pins_o));

// ### verification/bxc_host.sv
// Host model: serial port master that sends write frames
`timescale 1ns/100ps
module bxc_host (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  // Idle: clock still low, not selected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Frame of n bits, MSB first, data set while clock low, 320 ns bit period
  task automatic send(input logic [31:0] f, input int n);
    @(negedge clk_i) cs_n_o = 1'b0;
    repeat (8) @(negedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = f[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line shows no stale value
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// ### verification/bxc_ctrl_tb_top.sv
// Testbench: register writes and events against expected values
`timescale 1ns/100ps
module bxc_ctrl_tb_top;
  import bxc_pkg::*;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       sclk, cs_n, mosi;
  logic       transmit_data_input_i = 1'b1;
  logic       bus_dominant_i = 1'b0;
  logic       normal_mode_i = 1'b0;
  logic       low_power_i = 1'b0;
  logic       fail_detect_i = 1'b0;
  logic       fail_int_en_i = 1'b0;
  logic [7:0] xcvr_ctrl_o, pin_cfg_o;
  logic       xcvr_rx_en_o, xcvr_tx_en_o, xcvr_sleep_o, wake_o, int_o;
  bxc_slew_t  xcvr_slew_o;
  bxc_pins_t  pins_o;
  int         fail_count = 0;
  int         total_checks = 0;
  logic [15:0] wake_n = 16'h0000, int_n = 16'h0000, w0, i0; // Event pulse counts and marks

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // Event pulse counters, sampled mid-cycle while a pulse stands
  always @(negedge clk_i) begin
    if (wake_o === 1'b1) wake_n <= wake_n + 16'h0001;
    if (int_o === 1'b1) int_n <= int_n + 16'h0001;
  end

  bxc_host bxc_host_i (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  bxc_ctrl bxc_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .transmit_data_input_i(transmit_data_input_i), .bus_dominant_i(bus_dominant_i),
    .normal_mode_i(normal_mode_i), .low_power_i(low_power_i), .fail_detect_i(fail_detect_i),
    .fail_int_en_i(fail_int_en_i), .xcvr_ctrl_o(xcvr_ctrl_o), .pin_cfg_o(pin_cfg_o), .xcvr_rx_en_o(xcvr_rx_en_o),
    .xcvr_tx_en_o(xcvr_tx_en_o), .xcvr_sleep_o(xcvr_sleep_o), .xcvr_slew_o(xcvr_slew_o), .wake_o(wake_o),
    .int_o(int_o), .pins_o(pins_o));

  // ==========================================================
  // Tasks
  // ==========================================================
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Raw frame, then let the update and derived outputs settle
  task automatic raw(input logic [31:0] f, input int n);
    bxc_host_i.send(f, n);
    repeat (8) @(negedge clk_i);
  endtask

  // Register write
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    raw({16'h0000, OP_WRITE, a, 1'b0, d}, 16);
  endtask

  // Pulses on the bus line or on the transmit data line, 8 clocks each phase
  task automatic pulses(input bit txd, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      if (txd) transmit_data_input_i = 1'b0;
      else bus_dominant_i = 1'b1;
      repeat (8) @(negedge clk_i);
      transmit_data_input_i = 1'b1;
      bus_dominant_i = 1'b0;
      repeat (8) @(negedge clk_i);
    end
    repeat (4) @(negedge clk_i);
  endtask

  // Expected pin controls
  function automatic logic [15:0] exp_pins(input logic [7:0] v);
    bxc_pins_t r;
    for (int p = 0; p < 4; p++) begin
      r.wake_en[p] = (v[2*p +: 2] == 2'h1);
      r.ls_en[p]   = (p < 2) && (v[2*p +: 2] == 2'h2);
      r.hs_en[p]   = (v[2*p +: 2] == 2'h3) || ((p > 1) && (v[2*p +: 2] == 2'h2));
    end
    return 16'(r);
  endfunction

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #3000000;
    fail_count++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [7:0] v;
    logic [7:0] pv [6] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h1B, 8'hE4};
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("ctrl rst", 16'h0080, 16'(xcvr_ctrl_o));
    chk("pins rst", 16'h0000, 16'(pin_cfg_o));
    chk("sleep rst", 16'h0001, 16'(xcvr_sleep_o));
    $display("test reset done");
    foreach (pv[k]) begin
      wr(ADDR_PIN_CFG, pv[k]);
      chk("pin_cfg", 16'(pv[k]), 16'(pin_cfg_o));
      chk("pins", exp_pins(pv[k]), 16'(pins_o));
    end
    $display("test pins done");
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        v = {m[1:0], s[1:0], 4'h0};
        wr(ADDR_XCVR_CTRL, v);
        chk("ctrl", 16'(v), 16'(xcvr_ctrl_o));
        chk("rx", 16'(m[0]), 16'(xcvr_rx_en_o));
        chk("tx", 16'(m == 3), 16'(xcvr_tx_en_o));
        chk("sleep", 16'(!m[0]), 16'(xcvr_sleep_o));
        chk("slew", 16'((s == 1) ? SL_MEDIUM : (s == 2) ? SL_SLOW : SL_FAST), 16'(xcvr_slew_o));
      end
    end
    $display("test modes done");
    raw(32'h0000A03C, 16); // Wrong operation code
    raw(32'h0000643C, 16); // Unknown address
    raw(32'h0000301E, 15); // Short frame
    raw(32'h0000C078, 17); // Long frame
    chk("refused", 16'h00F0, 16'(xcvr_ctrl_o));
    $display("test refused done");
    wr(ADDR_XCVR_CTRL, 8'hC0);
    @(negedge clk_i) normal_mode_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("first normal", 16'h0080, 16'(xcvr_ctrl_o));
    normal_mode_i = 1'b0;
    wr(ADDR_XCVR_CTRL, 8'hC0);
    normal_mode_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("later normal", 16'h00C0, 16'(xcvr_ctrl_o));
    normal_mode_i = 1'b0;
    $display("test first normal done");
    wr(ADDR_XCVR_CTRL, 8'h80);
    low_power_i = 1'b1;
    w0 = wake_n;
    pulses(1'b0, 2);
    chk("wake 2 of 3", w0, wake_n);
    pulses(1'b0, 1);
    chk("wake 3 of 3", w0 + 16'h0001, wake_n);
    wr(ADDR_XCVR_CTRL, 8'h88);
    pulses(1'b0, 1);
    chk("wake single", w0 + 16'h0002, wake_n);
    low_power_i = 1'b0;
    normal_mode_i = 1'b1;
    i0 = int_n;
    pulses(1'b0, 1);
    chk("wake int", i0 + 16'h0001, int_n);
    chk("no wake", w0 + 16'h0002, wake_n);
    wr(ADDR_XCVR_CTRL, 8'h08);
    pulses(1'b0, 3);
    chk("off int", i0 + 16'h0001, int_n);
    normal_mode_i = 1'b0;
    $display("test wake done");
    wr(ADDR_XCVR_CTRL, 8'hC1);
    fail_int_en_i = 1'b1;
    fail_detect_i = 1'b1;
    repeat (8) @(negedge clk_i);
    chk("early fail", i0 + 16'h0002, int_n);
    fail_detect_i = 1'b0;
    wr(ADDR_XCVR_CTRL, 8'hC0);
    fail_detect_i = 1'b1;
    pulses(1'b1, 4);
    chk("fail 4 of 5", i0 + 16'h0002, int_n);
    pulses(1'b1, 1);
    chk("fail 5 of 5", i0 + 16'h0003, int_n);
    fail_detect_i = 1'b0;
    fail_int_en_i = 1'b0;
    wr(ADDR_XCVR_CTRL, 8'hC1);
    fail_detect_i = 1'b1;
    pulses(1'b1, 5);
    chk("fail masked", i0 + 16'h0003, int_n);
    fail_detect_i = 1'b0;
    $display("test failure done");
    tally_and_finish();
  end
endmodule
